/* File: hdl/aotc_output_test_regs.sv */
// Purpose: output format, offset trim and test pattern config with its datapath
// Assumes: register strobes, channel select and samples all on clk_sys
// Notes: reads return the lowest selected channel's per-channel fields
`timescale 1ns/1ps

module aotc_output_test_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [aotc_pkg::NUM_CH-1:0] chanSelect,
    input wire logic [15:0] userPattern1,
    input wire logic [15:0] userPattern2,
    input wire logic [aotc_pkg::NUM_CH-1:0][15:0] convSample,
    input wire logic [aotc_pkg::NUM_CH-1:0] convOverRange,
    input wire logic [aotc_pkg::NUM_CH-1:0] convUnderRange,
    output logic sampleEn,
    output logic chopEnable,
    output logic [2:0] swingSel,
    output logic [aotc_pkg::NUM_CH-1:0][15:0] linkData,
    output logic [aotc_pkg::NUM_CH-1:0][1:0] linkCtrl,
    output logic linkStrobe
);
    localparam int NCH = aotc_pkg::NUM_CH;

    aotc_pkg::aotc_glb_cfg_t glb_r;
    aotc_pkg::aotc_glb_cfg_t glb_nxt;
    aotc_pkg::aotc_chan_cfg_t cfgView [NCH];
    logic [2:0] divCnt_r;
    logic [2:0] divCnt_nxt;
    logic phase_r;
    logic phase_nxt;
    logic [3:0] walk_r;
    logic [3:0] walk_nxt;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic rdValid_r;
    logic wrTest;
    logic [aotc_pkg::PN_LONG_W-1:0] pnLong;
    logic [aotc_pkg::PN_SHORT_W-1:0] pnShort;

    assign wrTest = regWrEn && (regAddr == aotc_pkg::ADDR_TEST);

    // global registers: every channel sees them
    always_comb begin
        glb_nxt = glb_r;
        if (regWrEn) begin
            if (regAddr == aotc_pkg::ADDR_CLK_DIV) begin
                glb_nxt.divCode = regWrData[2:0];
            end else if (regAddr == aotc_pkg::ADDR_ENH) begin
                glb_nxt.chop = regWrData[aotc_pkg::CHOP_BIT];
            end else if (regAddr == aotc_pkg::ADDR_TEST) begin
                glb_nxt.pnLongRst = regWrData[aotc_pkg::PN_LONG_BIT];
                glb_nxt.pnShortRst = regWrData[aotc_pkg::PN_SHORT_BIT];
            end else if (regAddr == aotc_pkg::ADDR_FORMAT) begin
                glb_nxt.fmtTwos = regWrData[aotc_pkg::FMT_BIT];
                glb_nxt.csMode = regWrData[aotc_pkg::CS_LSB +: 3];
            end else if (regAddr == aotc_pkg::ADDR_SWING) begin
                glb_nxt.swing = regWrData[2:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            glb_r <= '{csMode: aotc_pkg::RST_CS, fmtTwos: aotc_pkg::RST_FMT,
                       pnLongRst: 1'b0, pnShortRst: 1'b0, chop: aotc_pkg::RST_CHOP,
                       divCode: aotc_pkg::RST_DIV, swing: aotc_pkg::RST_SWING};
        end else begin
            glb_r <= glb_nxt;
        end
    end

    // divider and pattern phase, stepped once per divided sample
    always_comb begin
        divCnt_nxt = divCnt_r + 3'h1;
        phase_nxt = phase_r;
        walk_nxt = walk_r;
        if (divCnt_r >= glb_r.divCode) begin
            divCnt_nxt = 3'h0;
            phase_nxt = ~phase_r;
            walk_nxt = walk_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            divCnt_r <= 3'h0;
            phase_r <= 1'b0;
            walk_r <= 4'h0;
        end else begin
            divCnt_r <= divCnt_nxt;
            phase_r <= phase_nxt;
            walk_r <= walk_nxt;
        end
    end

    assign sampleEn = !sys_rst && (divCnt_r >= glb_r.divCode);
    assign chopEnable = glb_r.chop;
    assign swingSel = glb_r.swing;

    // generators are shared, so one reset bit restarts every channel together
    aotc_pn_gen #(.W(aotc_pkg::PN_LONG_W), .TAP(aotc_pkg::PN_LONG_TAP)) uPnLong (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .step(sampleEn),
        .hold(glb_r.pnLongRst),
        .state(pnLong)
    );

    aotc_pn_gen #(.W(aotc_pkg::PN_SHORT_W), .TAP(aotc_pkg::PN_SHORT_TAP)) uPnShort (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .step(sampleEn),
        .hold(glb_r.pnShortRst),
        .state(pnShort)
    );

    for (genvar ch = 0; ch < NCH; ch++) begin : gCh
        aotc_pkg::aotc_chan_cfg_t cfg_r;
        aotc_pkg::aotc_chan_cfg_t cfg_nxt;
        logic [1:0] seqCnt_r;
        logic [1:0] seqCnt_nxt;
        logic [15:0] data_r;
        logic [15:0] data_nxt;
        logic [1:0] ctrl_r;
        logic [1:0] ctrl_nxt;
        logic [16:0] sum;
        logic [15:0] trimmed;
        logic [15:0] pattern;
        logic onceMode;
        logic seqDone;
        logic range;

        always_comb begin
            cfg_nxt = cfg_r;
            seqCnt_nxt = seqCnt_r;
            onceMode = cfg_r.userSeq[1];
            seqDone = onceMode && (seqCnt_r >= (cfg_r.userSeq[0] ? 2'h2 : 2'h1));
            if (regWrEn && chanSelect[ch]) begin
                if (regAddr == aotc_pkg::ADDR_TEST) begin
                    cfg_nxt.testMode = regWrData[3:0];
                    cfg_nxt.userSeq = regWrData[aotc_pkg::SEQ_LSB +: 2];
                end else if (regAddr == aotc_pkg::ADDR_OFFSET) begin
                    cfg_nxt.offset = regWrData;
                end else if (regAddr == aotc_pkg::ADDR_FORMAT) begin
                    cfg_nxt.validInv = regWrData[aotc_pkg::VALID_BIT];
                end
            end
            // sequence position, restarted by a test write that selects this channel
            if (wrTest && chanSelect[ch]) begin
                seqCnt_nxt = 2'h0;
            end else if (sampleEn && cfg_r.testMode == aotc_pkg::TM_USER) begin
                if (!onceMode) begin
                    seqCnt_nxt = {1'b0, ~seqCnt_r[0]};
                end else if (!seqDone) begin
                    seqCnt_nxt = seqCnt_r + 2'h1;
                end
            end
        end

        always_comb begin
            sum = {convSample[ch][15], convSample[ch]} + {{9{cfg_r.offset[7]}}, cfg_r.offset};
            trimmed = sum[15:0];
            if (sum[16] != sum[15]) begin
                trimmed = sum[16] ? 16'h8000 : 16'h7fff;
            end
            // offset binary flips the sign bit
            if (!glb_r.fmtTwos) begin
                trimmed[15] = ~trimmed[15];
            end
        end

        always_comb begin
            case (cfg_r.testMode)
                aotc_pkg::TM_MID: pattern = aotc_pkg::PAT_MID;
                aotc_pkg::TM_POS: pattern = aotc_pkg::PAT_POS;
                aotc_pkg::TM_NEG: pattern = aotc_pkg::PAT_NEG;
                aotc_pkg::TM_CHECK: pattern = phase_r ? ~aotc_pkg::PAT_CHECK : aotc_pkg::PAT_CHECK;
                aotc_pkg::TM_PN_LONG: pattern = pnLong[15:0];
                aotc_pkg::TM_PN_SHORT: pattern = {pnShort[6:0], pnShort};
                aotc_pkg::TM_WORD_TGL: pattern = phase_r ? ~aotc_pkg::PAT_NEG : aotc_pkg::PAT_NEG;
                aotc_pkg::TM_USER: begin
                    if (seqDone) begin
                        pattern = 16'h0000;
                    end else if (cfg_r.userSeq[0] && seqCnt_r[0]) begin
                        pattern = userPattern2;
                    end else begin
                        pattern = userPattern1;
                    end
                end
                aotc_pkg::TM_BIT_TGL: pattern = phase_r ? aotc_pkg::PAT_BIT_TGL : 16'h0000;
                aotc_pkg::TM_SYNC: pattern = aotc_pkg::PAT_SYNC;
                aotc_pkg::TM_ONE_HIGH: pattern = aotc_pkg::PAT_ONE << walk_r;
                aotc_pkg::TM_MIXED: pattern = phase_r ? ~aotc_pkg::PAT_MIXED : aotc_pkg::PAT_MIXED;
                default: pattern = trimmed;
            endcase
        end

        always_comb begin
            data_nxt = data_r;
            ctrl_nxt = ctrl_r;
            range = convOverRange[ch] | convUnderRange[ch];
            if (sampleEn) begin
                data_nxt = (cfg_r.testMode == aotc_pkg::TM_OFF) ? trimmed : pattern;
                // control bits, valid is active low in config
                case (glb_r.csMode)
                    aotc_pkg::CS_RANGE_VALID: ctrl_nxt = {range, ~cfg_r.validInv};
                    aotc_pkg::CS_OVR_UDR: ctrl_nxt = {convOverRange[ch], convUnderRange[ch]};
                    aotc_pkg::CS_RANGE_BLANK: ctrl_nxt = {range, 1'b0};
                    aotc_pkg::CS_BLANK_VALID: ctrl_nxt = {1'b0, ~cfg_r.validInv};
                    default: ctrl_nxt = 2'b00;
                endcase
            end
        end

        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                cfg_r <= '0;
                seqCnt_r <= 2'h0;
                data_r <= 16'h0000;
                ctrl_r <= 2'b00;
            end else begin
                cfg_r <= cfg_nxt;
                seqCnt_r <= seqCnt_nxt;
                data_r <= data_nxt;
                ctrl_r <= ctrl_nxt;
            end
        end

        assign cfgView[ch] = cfg_r;
        assign linkData[ch] = data_r;
        assign linkCtrl[ch] = ctrl_r;
    end

    // readback: lowest selected channel supplies per-channel fields
    always_comb begin
        aotc_pkg::aotc_chan_cfg_t rc;
        rc = cfgView[0];
        for (int i = NCH - 1; i >= 0; i--) begin
            if (chanSelect[i]) begin
                rc = cfgView[i];
            end
        end
        rdData_nxt = rdData_r;
        if (regRdEn) begin
            rdData_nxt = 8'h00;
            if (regAddr == aotc_pkg::ADDR_CLK_DIV) begin
                rdData_nxt[2:0] = glb_r.divCode;
            end else if (regAddr == aotc_pkg::ADDR_ENH) begin
                rdData_nxt[aotc_pkg::CHOP_BIT] = glb_r.chop;
            end else if (regAddr == aotc_pkg::ADDR_TEST) begin
                rdData_nxt = {rc.userSeq, glb_r.pnLongRst, glb_r.pnShortRst, rc.testMode};
            end else if (regAddr == aotc_pkg::ADDR_OFFSET) begin
                rdData_nxt = rc.offset;
            end else if (regAddr == aotc_pkg::ADDR_FORMAT) begin
                rdData_nxt = {glb_r.csMode, rc.validInv, 3'h0, glb_r.fmtTwos};
            end else if (regAddr == aotc_pkg::ADDR_SWING) begin
                rdData_nxt[2:0] = glb_r.swing;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdData_r <= 8'h00;
            rdValid_r <= 1'b0;
            linkStrobe <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= regRdEn;
            linkStrobe <= sampleEn;
        end
    end

    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;

    chk_div_ratio: assert property (@(posedge clk_sys) disable iff (sys_rst || regWrEn)
        sampleEn && glb_r.divCode == 3'h3 |=> !sampleEn [*3] ##1 sampleEn)
        else $error("divide by four spacing wrong");
    chk_chop_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
        regWrEn && regAddr == aotc_pkg::ADDR_ENH |=> chopEnable == $past(regWrData[2]))
        else $error("chop enable did not follow write");
    chk_test_override: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sampleEn && gCh[0].cfg_r.testMode == aotc_pkg::TM_POS |=> linkData[0] == 16'hffff)
        else $error("full scale pattern missing");
    chk_offset_pass: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sampleEn && gCh[0].cfg_r.testMode == 4'h0 && gCh[0].cfg_r.offset == 8'h7f
        && glb_r.fmtTwos && convSample[0] == 16'h1000 |=> linkData[0] == 16'h107f)
        else $error("offset trim not applied");
    chk_pn_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        glb_r.pnShortRst |=> pnShort == 9'h1ff)
        else $error("short generator not held at seed");
    chk_pn_global: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wrTest && !chanSelect[0] |=> glb_r.pnLongRst == $past(regWrData[5]))
        else $error("long generator reset not global");
    chk_perch_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        regWrEn && regAddr == aotc_pkg::ADDR_OFFSET && !chanSelect[2]
        |=> $stable(gCh[2].cfg_r.offset))
        else $error("unselected channel changed");
    chk_valid_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sampleEn && glb_r.csMode == 3'h3 |=> linkCtrl[3] == {1'b0, ~$past(gCh[3].cfg_r.validInv)})
        else $error("valid flag wrong");
    chk_user_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sampleEn && gCh[0].cfg_r.testMode == 4'h8 && gCh[0].cfg_r.userSeq == 2'h2
        && gCh[0].seqCnt_r == 2'h1 |=> linkData[0] == 16'h0000)
        else $error("once mode did not fall to zero");

    cov_user_alt: cover property (@(posedge clk_sys) disable iff (sys_rst)
        sampleEn && gCh[0].cfg_r.testMode == 4'h8 && gCh[0].cfg_r.userSeq == 2'h1);
    cov_pn_long: cover property (@(posedge clk_sys) disable iff (sys_rst)
        sampleEn && gCh[0].cfg_r.testMode == 4'h5);
    cov_div8: cover property (@(posedge clk_sys) disable iff (sys_rst)
        sampleEn && glb_r.divCode == 3'h7);
endmodule : aotc_output_test_regs

/* File: hdl/aotc_pn_gen.sv */
// Purpose: Fibonacci pseudo-random generator stepped by a sample enable
// Assumes: seed of all ones, two-tap feedback
// Notes: held at seed while hold is high
`timescale 1ns/1ps

module aotc_pn_gen #(
    parameter int W = 9,
    parameter int TAP = 5
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic step,
    input wire logic hold,
    output logic [W-1:0] state
);
    logic [W-1:0] lfsr_r;
    logic [W-1:0] lfsr_nxt;

    always_comb begin
        lfsr_nxt = lfsr_r;
        if (hold) begin
            lfsr_nxt = '1;
        end else if (step) begin
            lfsr_nxt = {lfsr_r[W-2:0], lfsr_r[W-1] ^ lfsr_r[TAP-1]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lfsr_r <= '1;
        end else begin
            lfsr_r <= lfsr_nxt;
        end
    end

    assign state = lfsr_r;
endmodule : aotc_pn_gen

/* File: pkg/aotc_pkg.sv */
// Purpose: constants and types for the converter output/test config registers
// Assumes: byte-wide register port, four channels, 16-bit samples

package aotc_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 16;

    localparam logic [7:0] ADDR_CLK_DIV = 8'h0b;
    localparam logic [7:0] ADDR_ENH = 8'h0c;
    localparam logic [7:0] ADDR_TEST = 8'h0d;
    localparam logic [7:0] ADDR_OFFSET = 8'h10;
    localparam logic [7:0] ADDR_FORMAT = 8'h14;
    localparam logic [7:0] ADDR_SWING = 8'h15;

    localparam logic [2:0] RST_DIV = 3'h0;
    localparam logic RST_CHOP = 1'b0;
    localparam logic RST_FMT = 1'b1;
    localparam logic [2:0] RST_CS = 3'h0;
    localparam logic [2:0] RST_SWING = 3'h3;

    localparam int CHOP_BIT = 2;
    localparam int PN_SHORT_BIT = 4;
    localparam int PN_LONG_BIT = 5;
    localparam int SEQ_LSB = 6;
    localparam int FMT_BIT = 0;
    localparam int VALID_BIT = 4;
    localparam int CS_LSB = 5;

    localparam logic [3:0] TM_OFF = 4'h0;
    localparam logic [3:0] TM_MID = 4'h1;
    localparam logic [3:0] TM_POS = 4'h2;
    localparam logic [3:0] TM_NEG = 4'h3;
    localparam logic [3:0] TM_CHECK = 4'h4;
    localparam logic [3:0] TM_PN_LONG = 4'h5;
    localparam logic [3:0] TM_PN_SHORT = 4'h6;
    localparam logic [3:0] TM_WORD_TGL = 4'h7;
    localparam logic [3:0] TM_USER = 4'h8;
    localparam logic [3:0] TM_BIT_TGL = 4'h9;
    localparam logic [3:0] TM_SYNC = 4'ha;
    localparam logic [3:0] TM_ONE_HIGH = 4'hb;
    localparam logic [3:0] TM_MIXED = 4'hc;

    localparam logic [1:0] SEQ_SINGLE = 2'h0;
    localparam logic [1:0] SEQ_ALT = 2'h1;
    localparam logic [1:0] SEQ_SINGLE_ONCE = 2'h2;
    localparam logic [1:0] SEQ_ALT_ONCE = 2'h3;

    localparam logic [2:0] CS_RANGE_VALID = 3'h0;
    localparam logic [2:0] CS_OVR_UDR = 3'h1;
    localparam logic [2:0] CS_RANGE_BLANK = 3'h2;
    localparam logic [2:0] CS_BLANK_VALID = 3'h3;

    localparam logic [15:0] PAT_MID = 16'h8000;
    localparam logic [15:0] PAT_POS = 16'hffff;
    localparam logic [15:0] PAT_NEG = 16'h0000;
    localparam logic [15:0] PAT_CHECK = 16'h5555;
    localparam logic [15:0] PAT_BIT_TGL = 16'h0001;
    localparam logic [15:0] PAT_SYNC = 16'h00ff;
    localparam logic [15:0] PAT_MIXED = 16'ha0f0;
    localparam logic [15:0] PAT_ONE = 16'h0001;

    localparam int PN_LONG_W = 23;
    localparam int PN_LONG_TAP = 18;
    localparam int PN_SHORT_W = 9;
    localparam int PN_SHORT_TAP = 5;

    typedef struct packed {
        logic [1:0] userSeq;
        logic [3:0] testMode;
        logic [7:0] offset;
        logic validInv;
    } aotc_chan_cfg_t;

    typedef struct packed {
        logic [2:0] csMode;
        logic fmtTwos;
        logic pnLongRst;
        logic pnShortRst;
        logic chop;
        logic [2:0] divCode;
        logic [2:0] swing;
    } aotc_glb_cfg_t;
endpackage : aotc_pkg

/* File: tb/aotc_host_model.sv */
// Purpose: host side of the register strobe port
// Assumes: strobes launched just after the clk_sys rising edge
// Notes: idle address and data show inverted junk, never the last value
`timescale 1ns/1ps

module aotc_host_model (
    input wire logic clk_sys,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1;
        v = regRdValid;
        d = regRdData;
    endtask : rd
endmodule : aotc_host_model

/* File: tb/tb_adc_output_test_config_regs.sv */
// Purpose: self-checking bench for the output/test config registers
// Assumes: divide by one during datapath checks, so a strobe every cycle
// Notes: datapath results are sampled on the falling edge, register reads 1 ns after the rising edge
`timescale 1ns/1ps

module tb_adc_output_test_config_regs;
    logic clk_sys, sys_rst, regWrEn, regRdEn, regRdValid, sampleEn, chopEnable, linkStrobe;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [3:0] chanSelect, ovr, udr;
    logic [15:0] pat1, pat2, a;
    logic [3:0][15:0] samp, linkData;
    logic [3:0][1:0] linkCtrl;
    logic [2:0] swingSel;
    int error_cnt = 0;
    int check_count = 0;

    aotc_host_model host (.clk_sys(clk_sys), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid));

    aotc_output_test_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .chanSelect(chanSelect), .userPattern1(pat1),
        .userPattern2(pat2), .convSample(samp), .convOverRange(ovr), .convUnderRange(udr),
        .sampleEn(sampleEn), .chopEnable(chopEnable), .swingSel(swingSel),
        .linkData(linkData), .linkCtrl(linkCtrl), .linkStrobe(linkStrobe));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // bounded wait for n data strobes
    task automatic strobes(input int n);
        int k;
        k = 0;
        repeat (n) begin
            do begin
                @(negedge clk_sys);
                k++;
            end while (linkStrobe !== 1'b1 && k < 300);
        end
        if (k >= 300) begin
            error_cnt++;
            give_verdict();
        end
    endtask : strobes

    task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.rd(ad, d, v);
        check("rd valid", 16'(v), 16'h0001);
        check("rd data", 16'(d), 16'(exp));
    endtask : rchk

    task automatic sel(input logic [3:0] s);
        @(posedge clk_sys);
        chanSelect <= s;
    endtask : sel

    task automatic t_reset();
        logic [7:0] ra [7] = '{8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h14, 8'h15, 8'h20};
        logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
        foreach (ra[i]) rchk(ra[i], rv[i]);
        check("swing", 16'(swingSel), 16'h0003);
    endtask : t_reset

    task automatic t_chop();
        host.wr(8'h0c, 8'h04);
        @(negedge clk_sys);
        check("chop on", 16'(chopEnable), 16'h0001);
        rchk(8'h0c, 8'h04);
        host.wr(8'h0c, 8'h00);
        @(negedge clk_sys);
        check("chop off", 16'(chopEnable), 16'h0000);
    endtask : t_chop

    task automatic t_div();
        int n;
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h0b, 8'(c));
            repeat (2) begin
                n = 0;
                do begin
                    @(negedge clk_sys);
                    n++;
                end while (sampleEn !== 1'b1 && n < 20);
            end
            check("div gap", 16'(n), 16'(c + 1));
            check("strobe lag", 16'(linkStrobe), 16'(c == 0));
        end
        host.wr(8'h0b, 8'h00);
    endtask : t_div

    task automatic t_pat();
        logic [7:0] cd [9] = '{8'h01, 8'h02, 8'h03, 8'h0a, 8'h41, 8'h04, 8'h07, 8'h09, 8'h0c};
        logic [15:0] ev [9] = '{16'h8000, 16'hffff, 16'h0000, 16'h00ff, 16'h8000,
            16'hffff, 16'hffff, 16'h0001, 16'hffff};
        foreach (cd[i]) begin
            host.wr(8'h0d, cd[i]);
            strobes(3);
            a = linkData[0];
            strobes(1);
            // toggling codes compared as xor of two samples
            check("pattern", (i < 5) ? linkData[0] : a ^ linkData[0], ev[i]);
            check("other ch", linkData[1], 16'h1234);
        end
        host.wr(8'h0d, 8'h0b);
        strobes(3);
        check("one high", 16'($countones(linkData[0])), 16'h0001);
    endtask : t_pat

    task automatic t_user();
        logic [7:0] cd [4] = '{8'h08, 8'h48, 8'h88, 8'hc8};
        logic [15:0] ev [4] = '{16'h1357, 16'h373f, 16'h0000, 16'h0000};
        foreach (cd[i]) begin
            host.wr(8'h0d, cd[i]);
            strobes(4);
            a = linkData[0];
            strobes(1);
            check("user seq", (i == 1) ? a ^ linkData[0] : linkData[0], ev[i]);
        end
    endtask : t_user

    task automatic t_pn();
        logic [7:0] cd [2] = '{8'h05, 8'h06};
        logic [7:0] rb [2] = '{8'h20, 8'h10};
        foreach (cd[i]) begin
            host.wr(8'h0d, cd[i]);
            sel(4'b0010);
            host.wr(8'h0d, rb[i]);
            strobes(3);
            check("pn held", linkData[0], 16'hffff);
            check("pn ch1", linkData[1], 16'h1234);
            sel(4'b0001);
            host.wr(8'h0d, cd[i]);
            strobes(3);
            a = linkData[0];
            strobes(1);
            check("pn runs", 16'(a === linkData[0]), 16'h0000);
        end
        host.wr(8'h0d, 8'h00);
    endtask : t_pn

    task automatic t_fmt();
        logic [7:0] oa [5] = '{8'h7f, 8'h80, 8'h80, 8'h7f, 8'h00};
        logic [7:0] fm [5] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h01};
        logic [15:0] s0 [5] = '{16'h1000, 16'h1000, 16'h1000, 16'h7fff, 16'h1000};
        logic [15:0] ev [5] = '{16'h107f, 16'h0f80, 16'h8f80, 16'h7fff, 16'h1000};
        foreach (oa[i]) begin
            @(posedge clk_sys);
            samp[0] <= s0[i];
            host.wr(8'h10, oa[i]);
            host.wr(8'h14, fm[i]);
            strobes(3);
            check("trim fmt", linkData[0], ev[i]);
            check("ch1 fmt", linkData[1], {~fm[i][0], 15'h1234});
        end
    endtask : t_fmt

    task automatic t_ctrl();
        logic [7:0] md [6] = '{8'h01, 8'h11, 8'h21, 8'h41, 8'h61, 8'h81};
        logic [1:0] ev [6] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h0};
        @(posedge clk_sys);
        ovr <= 4'h1;
        foreach (md[i]) begin
            host.wr(8'h14, md[i]);
            strobes(3);
            check("ctrl bits", 16'(linkCtrl[0]), 16'(ev[i]));
        end
        host.wr(8'h14, 8'h11);
        strobes(3);
        check("valid ch1", 16'(linkCtrl[1]), 16'h0001);
    endtask : t_ctrl

    initial begin
        sys_rst = 1'b1;
        chanSelect = 4'b0001;
        ovr = 4'h0;
        udr = 4'h0;
        pat1 = 16'h1357;
        pat2 = 16'h2468;
        samp = {4{16'h1234}};
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_chop();
        t_div();
        t_pat();
        t_user();
        t_pn();
        t_fmt();
        t_ctrl();
        give_verdict();
    end
endmodule : tb_adc_output_test_config_regs
